/* dv/fee_cpu_model.sv */
// cpu side byte bus master for the register bank
`timescale 1ns/1ps
module fee_cpu_model (
  input  wire        mclk_i,
  input  wire        ack_i,
  input  wire [7:0]  rdata_i,
  output reg         acc_o,
  output reg         wr_o,
  output reg  [15:0] addr_o,
  output reg  [7:0]  wdata_o
);
  // ==========================================
  // idle bus
  initial
  begin
    acc_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 8'h00;
  end
  // one byte access, held until ack is seen, bounded wait
  task xfer(input w, input [15:0] a, input [7:0] d, output [7:0] q, output ok);
    integer n;
    begin
      @(negedge mclk_i);
      acc_o = 1'b1;
      wr_o = w;
      addr_o = a;
      wdata_o = d;
      ok = 1'b0;
      q = 8'h00;
      for (n = 0; n < 8 && !ok; n = n + 1)
      begin
        @(posedge mclk_i);
        if (ack_i === 1'b1)
        begin
          ok = 1'b1;
          q = rdata_i;
        end
      end
      @(negedge mclk_i);
      acc_o = 1'b0;
      // released lines show garbage, so stale values cannot pass
      addr_o = ~addr_o;
      wdata_o = ~wdata_o;
    end
  endtask
endmodule

/* dv/fee_ctrl_regs_checker.sv */
// assertion checker for the flash erase and overlay control registers
`timescale 1ns/1ps
`include "fee_ctrl_map.vh"
module fee_ctrl_regs_checker #(
  parameter BLOCKS = 10
) (
  input logic        mclk_i,
  input logic        rst_i,
  input logic        acc_i,
  input logic        wr_i,
  input logic [15:0] addr_i,
  input logic        flash_disabled_i,
  input logic        software_write_enable_i,
  input logic        hw_standby_i,
  input logic        sw_standby_i,
  input logic        flash_error_event_i,
  input logic        subactive_i,
  input logic        subsleep_i,
  input logic [16:0] mem_addr_i,
  input logic [7:0]  rdata_o,
  input logic        ack_o,
  input logic        protect_o,
  input logic [9:0]  erase_allow_o,
  input logic        overlay_hit_o,
  input logic        powerdown_enter_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // bus handshake and read data
  property p_ack; acc_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_once; ack_o |=> !ack_o; endproperty
  a_once: assert property (p_once) else $error("ack longer than one cycle");
  sequence s_rd(a); acc_i && !ack_o && !wr_i && addr_i == a; endsequence
  property p_rsv; s_rd(`FEE_ADDR_STATUS) |=> rdata_o[6:0] == 7'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("status low bits not zero");
  property p_dis; acc_i && !ack_o && !wr_i && addr_i == `FEE_ADDR_SEL_HI && flash_disabled_i
    |=> rdata_o == 8'h00; endproperty
  a_dis: assert property (p_dis) else $error("select read while disabled");
  // ==========================================
  // protection, selects, power-down and overlay hit
  property p_one; $onehot0(erase_allow_o); endproperty
  a_one: assert property (p_one) else $error("several blocks allowed");
  property p_swe; !software_write_enable_i [*2] |=> erase_allow_o == 10'h000; endproperty
  a_swe: assert property (p_swe) else $error("select kept without enable");
  property p_err; flash_error_event_i && !hw_standby_i && !sw_standby_i |-> ##[1:2] protect_o;
  endproperty
  a_err: assert property (p_err) else $error("error did not protect");
  property p_pd; !subactive_i && !subsleep_i |=> !powerdown_enter_o; endproperty
  a_pd: assert property (p_pd) else $error("power-down outside low modes");
  property p_hit; overlay_hit_o |-> $past(mem_addr_i) < 17'h01000; endproperty
  a_hit: assert property (p_hit) else $error("overlay outside blocks 0 to 3");
  c_rd: cover property (ack_o && rdata_o != 8'h00);
  c_prot: cover property (protect_o);
  c_hit: cover property (overlay_hit_o);
endmodule
bind fee_ctrl_regs fee_ctrl_regs_checker #(.BLOCKS(BLOCKS)) u_chk (.mclk_i, .rst_i, .acc_i,
  .wr_i, .addr_i, .flash_disabled_i, .software_write_enable_i, .hw_standby_i, .sw_standby_i,
  .flash_error_event_i, .subactive_i, .subsleep_i, .mem_addr_i, .rdata_o, .ack_o, .protect_o,
  .erase_allow_o, .overlay_hit_o, .powerdown_enter_o);

/* dv/test_flash_erase_emul_ctrl_regs.sv */
// self-checking testbench for the flash erase and overlay control registers
`timescale 1ns/1ps
`include "fee_ctrl_map.vh"
module test_flash_erase_emul_ctrl_regs;
  reg mclk_i, rst_i, pin, swe, rae, dis, hws, sws, err, sa, ss;
  reg [16:0] ea, ma;
  wire acc, wr, ack, prot, ok, hit, pde, wes;
  wire [15:0] addr;
  wire [7:0] wd, rdata;
  wire [9:0] allow;
  integer mismatches, comparisons;
  reg [7:0] q;
  fee_ctrl_regs DUT (.mclk_i(mclk_i), .rst_i(rst_i), .acc_i(acc), .wr_i(wr), .addr_i(addr),
    .wdata_i(wd), .write_enable_pin_i(pin), .software_write_enable_i(swe),
    .register_access_enable_i(rae), .flash_disabled_i(dis), .hw_standby_i(hws),
    .sw_standby_i(sws), .flash_error_event_i(err), .subactive_i(sa), .subsleep_i(ss),
    .erase_addr_i(ea), .mem_addr_i(ma), .rdata_o(rdata), .ack_o(ack), .protect_o(prot),
    .erase_allow_o(allow), .erase_addr_ok_o(ok), .overlay_hit_o(hit),
    .powerdown_enter_o(pde), .write_enable_state_o(wes));
  fee_cpu_model cpu (.mclk_i(mclk_i), .ack_i(ack), .rdata_i(rdata), .acc_o(acc), .wr_o(wr),
    .addr_o(addr), .wdata_o(wd));
  // ==========================================
  // helpers
  task end_of_test;
    begin
      if (mismatches == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [9:0] got, input [9:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // byte read data against the expected register image
  task chk_byte(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // single status outputs; x or z counts as a mismatch
  task chk_bit(input got, input exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
      end
    end
  endtask
  task xf(input w, input [15:0] a, input [7:0] d);
    reg k;
    begin
      cpu.xfer(w, a, d, q, k);
      if (k !== 1'b1)
      begin
        mismatches = mismatches + 1;
        end_of_test;
      end
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      xf(1'b0, a, 8'h00);
      chk_byte(q, e);
    end
  endtask
  // dependent outputs land one edge after the ack
  task settle;
    repeat (3) @(negedge mclk_i);
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    begin
      rd(`FEE_ADDR_STATUS, 8'h00);
      rd(`FEE_ADDR_SEL_LO, 8'h00);
      rd(`FEE_ADDR_OVERLAY, 8'h00);
      rd(`FEE_ADDR_POWER, 8'h00);
    end
  endtask
  task t_select;
    begin
      xf(1'b1, `FEE_ADDR_SEL_LO, 8'h04);
      ea = 17'h00800;
      settle;
      chk(allow, 10'h004);
      chk_bit(ok, 1'b1);
      ea = 17'h00C00;
      settle;
      chk_bit(ok, 1'b0);
      xf(1'b1, `FEE_ADDR_SEL_HI, 8'h01);
      rd(`FEE_ADDR_SEL_LO, 8'h00);
      xf(1'b1, `FEE_ADDR_SEL_HI, 8'h02);
      ea = 17'h1FFFF;
      settle;
      chk_bit(ok, 1'b1);
      rae = 1'b0;
      rd(`FEE_ADDR_SEL_HI, 8'h00);
      rae = 1'b1;
      dis = 1'b1;
      xf(1'b1, `FEE_ADDR_SEL_LO, 8'h01);
      // high select still holds block 9, so a zero read proves the gate
      rd(`FEE_ADDR_SEL_HI, 8'h00);
      dis = 1'b0;
      rd(`FEE_ADDR_SEL_HI, 8'h02);
      pin = 1'b0;
      settle;
      chk_bit(wes, 1'b0);
      xf(1'b1, `FEE_ADDR_SEL_LO, 8'h01);
      rd(`FEE_ADDR_SEL_LO, 8'h00);
      pin = 1'b1;
      settle;
      rd(`FEE_ADDR_SEL_HI, 8'h00);
      // a live selection first, so the software-enable clear is visible
      xf(1'b1, `FEE_ADDR_SEL_LO, 8'h01);
      settle;
      chk(allow, 10'h001);
      swe = 1'b0;
      xf(1'b1, `FEE_ADDR_SEL_LO, 8'h01);
      rd(`FEE_ADDR_SEL_LO, 8'h00);
      swe = 1'b1;
    end
  endtask
  task t_error;
    begin
      xf(1'b1, `FEE_ADDR_STATUS, 8'hFF);
      rd(`FEE_ADDR_STATUS, 8'h00);
      err = 1'b1;
      settle;
      err = 1'b0;
      rd(`FEE_ADDR_STATUS, 8'h80);
      xf(1'b1, `FEE_ADDR_SEL_LO, 8'h10);
      settle;
      chk_bit(prot, 1'b1);
      chk(allow, 10'h000);
      hws = 1'b1;
      settle;
      hws = 1'b0;
      rd(`FEE_ADDR_STATUS, 8'h00);
    end
  endtask
  task t_overlay;
    begin
      xf(1'b1, `FEE_ADDR_OVERLAY, 8'h0A);
      rd(`FEE_ADDR_OVERLAY, 8'h0A);
      // emulated block touched before an unrelated access, hit checked after it
      ma = 17'h00900;
      xf(1'b1, `FEE_ADDR_POWER, 8'hFF);
      rd(`FEE_ADDR_POWER, 8'h80);
      chk_bit(hit, 1'b1);
      chk_bit(prot, 1'b1);
      sws = 1'b1;
      settle;
      sws = 1'b0;
      rd(`FEE_ADDR_OVERLAY, 8'h0A);
      rd(`FEE_ADDR_POWER, 8'h00);
      ma = 17'h00500;
      settle;
      chk_bit(hit, 1'b0);
      // back in the overlaid block, so only the overlay write clearing select bit and area can drop the hit
      ma = 17'h00900;
      xf(1'b1, `FEE_ADDR_OVERLAY, 8'h00);
      settle;
      chk_bit(hit, 1'b0);
      chk_bit(prot, 1'b0);
    end
  endtask
  task t_power;
    begin
      sa = 1'b1;
      settle;
      chk_bit(pde, 1'b1);
      xf(1'b1, `FEE_ADDR_POWER, 8'h80);
      settle;
      chk_bit(pde, 1'b0);
      sa = 1'b0;
      settle;
      chk_bit(pde, 1'b0);
      xf(1'b1, `FEE_ADDR_POWER, 8'h00);
      ss = 1'b1;
      settle;
      chk_bit(pde, 1'b1);
      ss = 1'b0;
    end
  endtask
  // ==========================================
  // clock and main sequence
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial
  begin
    {rst_i, pin, swe, rae} = 4'hF;
    {dis, hws, sws, err, sa, ss} = 6'h00;
    ea = 17'h00000;
    ma = 17'h00000;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    t_reset;
    t_select;
    t_error;
    t_overlay;
    t_power;
    end_of_test;
  end
endmodule

/* src/fee_ctrl_map.vh */
// register addresses, field positions, reset values and erase block bounds
`ifndef FEE_CTRL_MAP_VH
`define FEE_CTRL_MAP_VH
// ==========================================
// register addresses (lower 16 bits)
`define FEE_ADDR_STATUS   16'hFFA9
`define FEE_ADDR_SEL_LO   16'hFFAA
`define FEE_ADDR_SEL_HI   16'hFFAB
`define FEE_ADDR_OVERLAY  16'hFEDB
`define FEE_ADDR_POWER    16'hFFAC
// ==========================================
// field positions
`define FEE_ERR_BIT       7
`define FEE_INHIBIT_BIT   7
`define FEE_OVL_SEL_BIT   3
`define FEE_OVL_HI_BIT    1
`define FEE_OVL_LO_BIT    0
`define FEE_OVL_KEEP_W    5
`define FEE_SEL_HI_W      2
// ==========================================
// reset values
`define FEE_RST_STATUS    8'h00
`define FEE_RST_SEL_LO    8'h00
`define FEE_RST_SEL_HI    2'h0
`define FEE_RST_OVERLAY   5'h00
`define FEE_RST_POWER     1'b0
// ==========================================
// last address of each erase block
`define FEE_END_B0        17'h003FF
`define FEE_END_B1        17'h007FF
`define FEE_END_B2        17'h00BFF
`define FEE_END_B3        17'h00FFF
`define FEE_END_B4        17'h07FFF
`define FEE_END_B5        17'h0BFFF
`define FEE_END_B6        17'h0DFFF
`define FEE_END_B7        17'h0FFFF
`define FEE_END_B8        17'h17FFF
`define FEE_END_B9        17'h1FFFF
`define FEE_NO_BLOCK      4'hF
`endif

/* src/fee_ctrl_regs.v */
// flash error, erase select, ram overlay and power-down control registers
//
// Function
// - status register clears on power-on reset, hardware or software standby.
// - error flag sets on program/erase error and holds error protection.
// - error flag clears only by power-on reset, hardware or software standby.
// - status bits 6-0 and power bits 6-0 read zero.
// - flash disabled: status and erase-select read zero, writes ignored.
// - erase selects clear on reset, standby, pin low, or software enable clear.
// - only the block with its select bit set may be erased.
// - more than one select bit set clears both select registers.
// - upper select uses bits 1-0 only; bits 7-2 written zero.
// - fixed erase block address map over the 128 kbyte array.
// - overlay register clears on reset and hardware standby, kept in software standby.
// - overlay select set protects every block from program and erase.
// - overlay area field picks block 0 to 3 for the ram overlay.
// - overlay bits 7-5 read zero; bits 4 and 2 written zero.
// - power-down inhibit set blocks flash power-down on subactive entry.
// - power-down inhibit acts only in subactive or subsleep mode.
// - power register clears on reset, hardware or software standby.
// - status and erase-select reachable only with register access enable set.
// - erase-select writes ignored unless the write-enable pin is high.
// - byte-wide registers, every access takes two bus states.
`timescale 1ns/1ps
`include "fee_ctrl_map.vh"

module fee_ctrl_regs #(
  parameter BLOCKS = 10
) (
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire        acc_i,
  input  wire        wr_i,
  input  wire [15:0] addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        write_enable_pin_i,
  input  wire        software_write_enable_i,
  input  wire        register_access_enable_i,
  input  wire        flash_disabled_i,
  input  wire        hw_standby_i,
  input  wire        sw_standby_i,
  input  wire        flash_error_event_i,
  input  wire        subactive_i,
  input  wire        subsleep_i,
  input  wire [16:0] erase_addr_i,
  input  wire [16:0] mem_addr_i,
  output reg  [7:0]  rdata_o,
  output reg         ack_o,
  output reg         protect_o,
  output reg  [9:0]  erase_allow_o,
  output reg         erase_addr_ok_o,
  output reg         overlay_hit_o,
  output reg         powerdown_enter_o,
  output reg         write_enable_state_o
);

  // ==========================================
  // state

  reg        pin_meta;
  reg        pin_sync;
  reg        flash_error_flag;
  reg [7:0]  erase_block_select_low;
  reg [1:0]  erase_block_select_high;
  reg [4:0]  ram_overlay_control;
  reg        powerdown_inhibit;

  wire       overlay_select;
  wire [1:0] overlay_area;
  wire       protect_all;
  wire       accept;
  wire       do_write;
  wire       flash_regs_open;
  wire       sel_write_ok;
  wire       sel_clear;
  wire       in_low_power;
  wire [9:0] sel_now;
  wire [3:0] erase_blk;
  wire [3:0] mem_blk;

  reg  [9:0] next_sel;
  reg  [7:0] next_rdata;

  // ==========================================
  // block decode

  // returns block index 0..9 for an array address
  function [3:0] fee_block_of;
    input [16:0] a;
    begin
      if (a <= `FEE_END_B0)
        fee_block_of = 4'h0;
      else if (a <= `FEE_END_B1)
        fee_block_of = 4'h1;
      else if (a <= `FEE_END_B2)
        fee_block_of = 4'h2;
      else if (a <= `FEE_END_B3)
        fee_block_of = 4'h3;
      else if (a <= `FEE_END_B4)
        fee_block_of = 4'h4;
      else if (a <= `FEE_END_B5)
        fee_block_of = 4'h5;
      else if (a <= `FEE_END_B6)
        fee_block_of = 4'h6;
      else if (a <= `FEE_END_B7)
        fee_block_of = 4'h7;
      else if (a <= `FEE_END_B8)
        fee_block_of = 4'h8;
      else if (a <= `FEE_END_B9)
        fee_block_of = 4'h9;
      else
        fee_block_of = `FEE_NO_BLOCK;
    end
  endfunction

  assign erase_blk = fee_block_of(erase_addr_i);
  assign mem_blk   = fee_block_of(mem_addr_i);

  // ==========================================
  // combinational controls

  assign overlay_select = ram_overlay_control[`FEE_OVL_SEL_BIT];
  assign overlay_area   = {ram_overlay_control[`FEE_OVL_HI_BIT],
                           ram_overlay_control[`FEE_OVL_LO_BIT]};
  // either source shuts out program and erase
  assign protect_all    = flash_error_flag | overlay_select;

  // second state of an access is busy, so one access per two states
  assign accept   = acc_i & ~ack_o;
  assign do_write = accept & wr_i;

  // gate for status and erase-select, others stay reachable
  assign flash_regs_open = register_access_enable_i & ~flash_disabled_i;
  assign sel_write_ok    = flash_regs_open & pin_sync;

  // held clear while the pin or the software enable forbids erasing
  assign sel_clear = sw_standby_i | hw_standby_i | ~pin_sync
                   | ~software_write_enable_i;

  assign sel_now      = {erase_block_select_high, erase_block_select_low};
  assign in_low_power = subactive_i | subsleep_i;

  // ==========================================
  // pin synchroniser

  // write-enable pin is asynchronous to mclk_i
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= write_enable_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================
  // error flag

  // no software path clears it; only standby or reset
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      flash_error_flag <= 1'b0;
    else if (hw_standby_i)
      flash_error_flag <= 1'b0;
    else if (sw_standby_i)
      flash_error_flag <= 1'b0;
    else if (flash_error_event_i)
      flash_error_flag <= 1'b1;
  end

  // ==========================================
  // erase select next value

  // a write that leaves two bits set wipes both registers
  always @*
  begin
    next_sel = sel_now;
    if (do_write && sel_write_ok && addr_i == `FEE_ADDR_SEL_LO)
      next_sel = {erase_block_select_high, wdata_i};
    else if (do_write && sel_write_ok && addr_i == `FEE_ADDR_SEL_HI)
      next_sel = {wdata_i[`FEE_SEL_HI_W-1:0], erase_block_select_low};
    if ((next_sel & (next_sel - 10'h001)) != 10'h000)
      next_sel = 10'h000;
  end

  // ==========================================
  // erase select registers

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      erase_block_select_low  <= `FEE_RST_SEL_LO;
      erase_block_select_high <= `FEE_RST_SEL_HI;
    end
    else if (sel_clear)
    begin
      erase_block_select_low  <= `FEE_RST_SEL_LO;
      erase_block_select_high <= `FEE_RST_SEL_HI;
    end
    else
    begin
      erase_block_select_low  <= next_sel[7:0];
      erase_block_select_high <= next_sel[9:8];
    end
  end

  // ==========================================
  // overlay and power registers

  // overlay survives software standby so emulation resumes after wakeup
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      ram_overlay_control <= `FEE_RST_OVERLAY;
    else if (hw_standby_i)
      ram_overlay_control <= `FEE_RST_OVERLAY;
    else if (do_write && addr_i == `FEE_ADDR_OVERLAY)
      ram_overlay_control <= wdata_i[`FEE_OVL_KEEP_W-1:0];
  end

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      powerdown_inhibit <= `FEE_RST_POWER;
    else if (hw_standby_i || sw_standby_i)
      powerdown_inhibit <= `FEE_RST_POWER;
    else if (do_write && addr_i == `FEE_ADDR_POWER)
      powerdown_inhibit <= wdata_i[`FEE_INHIBIT_BIT];
  end

  // ==========================================
  // read mux

  // status writes fall through here and change nothing
  always @*
  begin
    next_rdata = 8'h00;
    case (addr_i)
      `FEE_ADDR_STATUS:
        if (flash_regs_open)
          next_rdata = {flash_error_flag, 7'h00};
      `FEE_ADDR_SEL_LO:
        if (flash_regs_open)
          next_rdata = erase_block_select_low;
      `FEE_ADDR_SEL_HI:
        if (flash_regs_open)
          next_rdata = {6'h00, erase_block_select_high};
      `FEE_ADDR_OVERLAY:
        next_rdata = {3'h0, ram_overlay_control};
      `FEE_ADDR_POWER:
        next_rdata = {powerdown_inhibit, 7'h00};
      default:
        next_rdata = 8'h00;
    endcase
  end

  // ==========================================
  // bus answer

  // data and ack appear in the second state of the access
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_o   <= 1'b0;
      rdata_o <= 8'h00;
    end
    else
    begin
      ack_o <= accept;
      if (accept && !wr_i)
        rdata_o <= next_rdata;
      else
        rdata_o <= 8'h00;
    end
  end

  // ==========================================
  // control outputs

  // registered, so they trail register contents by one state
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      protect_o            <= 1'b0;
      erase_allow_o        <= 10'h000;
      erase_addr_ok_o      <= 1'b0;
      overlay_hit_o        <= 1'b0;
      powerdown_enter_o    <= 1'b0;
      write_enable_state_o <= 1'b0;
    end
    else
    begin
      protect_o <= protect_all;
      erase_allow_o <= sel_now & {BLOCKS{~protect_all}};
      erase_addr_ok_o <= ~protect_all && erase_blk != `FEE_NO_BLOCK
                         && sel_now[erase_blk];
      overlay_hit_o <= overlay_select
                       && mem_blk == {2'b00, overlay_area};
      powerdown_enter_o <= in_low_power & ~powerdown_inhibit;
      write_enable_state_o <= pin_sync;
    end
  end

endmodule
